// ===== design/srg_serial.sv
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// [R1] internal generator overflow sets bit rate
// [R2] generator clocks modes 1, 3, optionally 0
// [R3] timer 1 overflow, doubler bit, sets rate
// [R4] software normally uses 8-bit auto-reload timer
// [R5] software keeps timer 1 interrupt disabled
// [R6] slow rates: 16-bit timer, software reload
// [R7] clock select bits enter timer 2 rate mode
// [R8] high byte overflow reloads 16-bit count
// [R9] rate mode counts every state time
// [R10] rate mode overflow sets no flag
// [R11] trigger falling edge sets flag, no reload
// [R12] software stops timer 2 before accesses
// [R13] mode 0: eight bits, LSB first
// [R14] buffer write starts send, marker bit nine
// [R15] one machine cycle before send active
// [R16] send drives data and shift clock pins
// [R17] shift clock low S3 to S5
// [R18] S6P2 shifts transmit register right, zero fill
// [R19] marker reached: last shift, stop, flag
// [R20] receive start loads 11111110, then active
// [R21] clock toggles S3P1/S6P1, shift at S6P2
// [R22] zero at left: load buffer, set flag
// [R23] transmit and receive sources chosen independently
// [R24] software clears flags, hardware sets them
// [R25] generator reloads on every overflow

module srg_serial (
	input  wire logic                   mclk,
	input  wire logic                   srst,
	input  wire srg_pkg::srg_axi_in_t   axi_in,
	output      srg_pkg::srg_axi_out_t  axi_out,
	input  wire logic                   timer1_overflow,
	input  wire srg_pkg::srg_pins_in_t  pins_in,
	output      srg_pkg::srg_pins_out_t pins_out,
	output      srg_pkg::srg_rate_t     rate_out
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic                      aw_rdy;
		logic [7:0]                aw_addr;
		logic                      w_rdy;
		logic [31:0]               w_data;
		logic [3:0]                w_strb;
		logic                      b_vld;
		logic [1:0]                b_resp;
		logic                      ar_rdy;
		logic                      r_vld;
		logic [31:0]               r_data;
		logic [1:0]                r_resp;
		logic [1:0]                mode;
		logic                      ren;
		logic                      tx_done_flag;
		logic                      rx_done_flag;
		logic [7:0]                serial_buffer;
		logic                      mode0_rate_source;
		logic                      rate_speed_select;
		logic                      tx_internal_select;
		logic                      rx_internal_select;
		logic                      gen_run;
		logic [7:0]                rate_reload_value;
		logic                      timer_rate_doubler;
		logic                      gen_rate_doubler;
		logic                      timer_two_overflow_flag;
		logic                      ext_trigger_flag;
		logic                      rx_clock_select;
		logic                      tx_clock_select;
		logic                      ext_trigger_enable;
		logic                      timer_two_run;
		logic                      timer_two_count_select;
		logic [15:0]               t2_count;
		logic [15:0]               t2_reload;
		logic [3:0]                phase;
		logic                      state_tog;
		logic [7:0]                gen_cnt;
		logic [2:0]                gen_pre;
		logic                      gen_half;
		logic                      t1_half;
		logic                      tx_rate;
		logic                      rx_rate;
		logic [8:0]                tx_shift;
		logic                      tx_pend;
		logic                      tx_arm;
		logic                      send;
		logic                      tx_last;
		logic [7:0]                rx_shift;
		logic                      rx_arm;
		logic                      receive;
		logic                      rx_last;
		logic                      rx_sample;
		logic                      sclk;
		logic                      dout;
		logic                      doe;
		logic [srg_pkg::N_SYNC-1:0] sy1;
		logic [srg_pkg::N_SYNC-1:0] sy2;
		logic [srg_pkg::N_SYNC-1:0] sy3;
		logic [srg_pkg::N_SYNC-1:0] flt;
	} srg_state_t;

	srg_state_t s_reg;
	srg_state_t s_next;

	logic [srg_pkg::N_SYNC-1:0] fall;
	logic                       phase_adv;
	logic                       gen_inc;
	logic                       gen_ovf;
	logic                       gen_tick;
	logic                       t1_tick;
	logic                       rate_mode;
	logic                       t2_inc;
	logic                       t2_ovf;
	logic                       mc_tick;
	logic                       tx_src;
	logic                       rx_src;
	logic                       mode0;
	logic                       wr_go;
	logic [31:0]                rd_val;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic reg_mapped(input logic [7:0] a);
		case (a)
			srg_pkg::OFS_CTRL, srg_pkg::OFS_SERIAL_BUFFER, srg_pkg::OFS_RGC,
			srg_pkg::OFS_BRL, srg_pkg::OFS_PWR, srg_pkg::OFS_T2C,
			srg_pkg::OFS_T2CNT, srg_pkg::OFS_T2CAP, srg_pkg::OFS_STAT: reg_mapped = 1'b1;
			default: reg_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic at_phase(input logic adv, input logic [3:0] ph,
					  input logic [3:0] want);
		at_phase = adv && (ph == want);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_next = s_reg;
		fall = '0;
		rd_val = '0;
		mode0 = (s_reg.mode == srg_pkg::MODE_SHIFT);

		// pins: three stages, a change counts once stages two and three agree
		s_next.sy1 = pins_in;
		s_next.sy2 = s_reg.sy1;
		s_next.sy3 = s_reg.sy2;
		for (int i = 0; i < srg_pkg::N_SYNC; i++) begin
			if (s_reg.sy2[i] == s_reg.sy3[i]) begin
				s_next.flt[i] = s_reg.sy3[i];
				fall[i] = s_reg.flt[i] & ~s_reg.sy3[i];
			end
		end

		// internal rate generator
		gen_inc = s_reg.gen_run & (s_reg.rate_speed_select | (s_reg.gen_pre == srg_pkg::BRG_SLOW_LAST));
		if (s_reg.gen_run) begin
			s_next.gen_pre = gen_inc ? 3'h0 : 3'(s_reg.gen_pre + 3'h1);
		end
		gen_ovf = gen_inc & (s_reg.gen_cnt == 8'hFF);
		if (gen_inc) begin
			s_next.gen_cnt = gen_ovf ? s_reg.rate_reload_value : 8'(s_reg.gen_cnt + 8'h01); // [R25]
		end
		if (gen_ovf) begin
			s_next.gen_half = ~s_reg.gen_half;
		end
		gen_tick = gen_ovf & (s_reg.gen_rate_doubler | s_reg.gen_half); // [R1]

		// timer 1 overflow, halved unless doubled
		if (timer1_overflow) begin
			s_next.t1_half = ~s_reg.t1_half;
		end
		t1_tick = timer1_overflow & (s_reg.timer_rate_doubler | s_reg.t1_half); // [R3]

		// machine cycle phases; mode 0 may step on the internal generator instead
		phase_adv = (mode0 && s_reg.mode0_rate_source) ? gen_tick : 1'b1; // [R2]
		if (phase_adv) begin
			s_next.phase = (s_reg.phase == srg_pkg::PH_S6P2) ? srg_pkg::PH_S1P1 :
					4'(s_reg.phase + 4'h1);
		end
		mc_tick = at_phase(phase_adv, s_reg.phase, srg_pkg::PH_S6P2);
		s_next.state_tog = ~s_reg.state_tog;

		// timer 2
		rate_mode = s_reg.tx_clock_select | s_reg.rx_clock_select; // [R7]
		t2_inc = s_reg.timer_two_run & (s_reg.timer_two_count_select ? fall[srg_pkg::SY_CNT] :
				(rate_mode ? s_reg.state_tog : mc_tick)); // [R9]
		t2_ovf = t2_inc & (s_reg.t2_count == 16'hFFFF);

		// bus slave: write side, taken in either order
		if (s_reg.aw_rdy && axi_in.awvalid) begin
			s_next.aw_addr = axi_in.awaddr;
			s_next.aw_rdy = 1'b0;
		end
		if (s_reg.w_rdy && axi_in.wvalid) begin
			s_next.w_data = axi_in.wdata;
			s_next.w_strb = axi_in.wstrb;
			s_next.w_rdy = 1'b0;
		end
		wr_go = !s_reg.aw_rdy && !s_reg.w_rdy && !s_reg.b_vld;
		if (wr_go) begin
			s_next.b_vld = 1'b1;
			s_next.b_resp = reg_mapped(s_reg.aw_addr) ? srg_pkg::RESP_OKAY : srg_pkg::RESP_SLVERR;
			if (s_reg.w_strb[0]) begin
				case (s_reg.aw_addr)
					srg_pkg::OFS_CTRL: begin
						s_next.mode = s_reg.w_data[srg_pkg::CTRL_MODE +: 2];
						s_next.ren = s_reg.w_data[srg_pkg::CTRL_REN];
						s_next.tx_done_flag = s_reg.w_data[srg_pkg::CTRL_TI]; // [R24]
						s_next.rx_done_flag = s_reg.w_data[srg_pkg::CTRL_RI]; // [R24]
					end
					srg_pkg::OFS_SERIAL_BUFFER: begin
						// writes while a byte is still in flight are dropped
						if (mode0 && !s_reg.send && !s_reg.tx_pend && !s_reg.tx_arm) begin
							s_next.tx_shift = {1'b1, s_reg.w_data[7:0]}; // [R14]
							s_next.tx_pend = 1'b1; // [R14]
						end
					end
					srg_pkg::OFS_RGC: begin
						s_next.mode0_rate_source = s_reg.w_data[srg_pkg::RGC_SRC];
						s_next.rate_speed_select = s_reg.w_data[srg_pkg::RGC_SPD];
						s_next.tx_internal_select = s_reg.w_data[srg_pkg::RGC_TX_INTERNAL_SELECT];
						s_next.rx_internal_select = s_reg.w_data[srg_pkg::RGC_RX_INTERNAL_SELECT];
						s_next.gen_run = s_reg.w_data[srg_pkg::RGC_RUN];
					end
					srg_pkg::OFS_BRL: s_next.rate_reload_value = s_reg.w_data[7:0];
					srg_pkg::OFS_PWR: begin
						s_next.timer_rate_doubler = s_reg.w_data[srg_pkg::PWR_TIMER_RATE_DOUBLER];
						s_next.gen_rate_doubler = s_reg.w_data[srg_pkg::PWR_GEN_RATE_DOUBLER];
					end
					srg_pkg::OFS_T2C: begin
						s_next.timer_two_overflow_flag = s_reg.w_data[srg_pkg::T2C_TF2];
						s_next.ext_trigger_flag = s_reg.w_data[srg_pkg::T2C_EXT_TRIGGER_FLAG];
						s_next.rx_clock_select = s_reg.w_data[srg_pkg::T2C_RCLK];
						s_next.tx_clock_select = s_reg.w_data[srg_pkg::T2C_TX_CLOCK_SELECT];
						s_next.ext_trigger_enable = s_reg.w_data[srg_pkg::T2C_EXT_TRIGGER_ENABLE];
						s_next.timer_two_run = s_reg.w_data[srg_pkg::T2C_TR2];
						s_next.timer_two_count_select = s_reg.w_data[srg_pkg::T2C_CT2];
					end
					srg_pkg::OFS_T2CNT: s_next.t2_count[7:0] = s_reg.w_data[7:0];
					srg_pkg::OFS_T2CAP: s_next.t2_reload[7:0] = s_reg.w_data[7:0];
					default: ;
				endcase
			end
			if (s_reg.w_strb[1]) begin
				case (s_reg.aw_addr)
					srg_pkg::OFS_T2CNT: s_next.t2_count[15:8] = s_reg.w_data[15:8];
					srg_pkg::OFS_T2CAP: s_next.t2_reload[15:8] = s_reg.w_data[15:8];
					default: ;
				endcase
			end
		end
		if (s_reg.b_vld && axi_in.bready) begin
			s_next.b_vld = 1'b0;
			s_next.aw_rdy = 1'b1;
			s_next.w_rdy = 1'b1;
		end

		// bus slave: read side
		case (axi_in.araddr)
			srg_pkg::OFS_CTRL: begin
				rd_val[srg_pkg::CTRL_MODE +: 2] = s_reg.mode;
				rd_val[srg_pkg::CTRL_REN] = s_reg.ren;
				rd_val[srg_pkg::CTRL_TI] = s_reg.tx_done_flag;
				rd_val[srg_pkg::CTRL_RI] = s_reg.rx_done_flag;
			end
			srg_pkg::OFS_SERIAL_BUFFER: rd_val[7:0] = s_reg.serial_buffer;
			srg_pkg::OFS_RGC: begin
				rd_val[srg_pkg::RGC_SRC] = s_reg.mode0_rate_source;
				rd_val[srg_pkg::RGC_SPD] = s_reg.rate_speed_select;
				rd_val[srg_pkg::RGC_TX_INTERNAL_SELECT] = s_reg.tx_internal_select;
				rd_val[srg_pkg::RGC_RX_INTERNAL_SELECT] = s_reg.rx_internal_select;
				rd_val[srg_pkg::RGC_RUN] = s_reg.gen_run;
			end
			srg_pkg::OFS_BRL: rd_val[7:0] = s_reg.rate_reload_value;
			srg_pkg::OFS_PWR: begin
				rd_val[srg_pkg::PWR_TIMER_RATE_DOUBLER] = s_reg.timer_rate_doubler;
				rd_val[srg_pkg::PWR_GEN_RATE_DOUBLER] = s_reg.gen_rate_doubler;
			end
			srg_pkg::OFS_T2C: begin
				rd_val[srg_pkg::T2C_TF2] = s_reg.timer_two_overflow_flag;
				rd_val[srg_pkg::T2C_EXT_TRIGGER_FLAG] = s_reg.ext_trigger_flag;
				rd_val[srg_pkg::T2C_RCLK] = s_reg.rx_clock_select;
				rd_val[srg_pkg::T2C_TX_CLOCK_SELECT] = s_reg.tx_clock_select;
				rd_val[srg_pkg::T2C_EXT_TRIGGER_ENABLE] = s_reg.ext_trigger_enable;
				rd_val[srg_pkg::T2C_TR2] = s_reg.timer_two_run;
				rd_val[srg_pkg::T2C_CT2] = s_reg.timer_two_count_select;
			end
			srg_pkg::OFS_T2CNT: rd_val[15:0] = s_reg.t2_count;
			srg_pkg::OFS_T2CAP: rd_val[15:0] = s_reg.t2_reload;
			srg_pkg::OFS_STAT: begin
				rd_val[srg_pkg::STAT_SEND] = s_reg.send;
				rd_val[srg_pkg::STAT_RECV] = s_reg.receive;
				rd_val[srg_pkg::STAT_PEND] = s_reg.tx_pend | s_reg.tx_arm;
				rd_val[srg_pkg::STAT_PHASE +: 4] = s_reg.phase;
			end
			default: ;
		endcase
		if (s_reg.ar_rdy && axi_in.arvalid) begin
			s_next.ar_rdy = 1'b0;
			s_next.r_vld = 1'b1;
			s_next.r_data = rd_val;
			s_next.r_resp = reg_mapped(axi_in.araddr) ? srg_pkg::RESP_OKAY : srg_pkg::RESP_SLVERR;
		end
		if (s_reg.r_vld && axi_in.rready) begin
			s_next.r_vld = 1'b0;
			s_next.ar_rdy = 1'b1;
		end

		// timer 2 count; hardware events come after software so they win
		// a count write while running can be lost to the increment
		if (t2_inc) begin
			s_next.t2_count = t2_ovf ? s_reg.t2_reload : 16'(s_reg.t2_count + 16'h0001); // [R8]
		end
		if (t2_ovf && !rate_mode) begin
			s_next.timer_two_overflow_flag = 1'b1; // [R10]
		end
		if (s_reg.ext_trigger_enable && fall[srg_pkg::SY_TRIG]) begin
			s_next.ext_trigger_flag = 1'b1; // [R11]
			if (!rate_mode) begin
				s_next.t2_count = s_reg.t2_reload;
			end
		end

		// rate ticks for modes 1 and 3
		tx_src = s_reg.tx_internal_select ? gen_tick : (s_reg.tx_clock_select ? t2_ovf : t1_tick); // [R23]
		rx_src = s_reg.rx_internal_select ? gen_tick : (s_reg.rx_clock_select ? t2_ovf : t1_tick); // [R23]
		s_next.tx_rate = s_reg.mode[0] & tx_src; // [R2]
		s_next.rx_rate = s_reg.mode[0] & rx_src; // [R2]

		// mode 0 transmit
		if (at_phase(phase_adv, s_reg.phase, srg_pkg::PH_S6P2)) begin
			if (s_reg.send) begin
				s_next.tx_shift = {1'b0, s_reg.tx_shift[8:1]}; // [R18]
				if (s_reg.tx_shift[8:1] == srg_pkg::TX_MARK_AT) begin
					s_next.tx_last = 1'b1; // [R19]
				end
			end else if (s_reg.tx_arm) begin
				s_next.send = 1'b1; // [R15]
				s_next.tx_arm = 1'b0;
			end else if (s_reg.tx_pend) begin
				s_next.tx_arm = 1'b1; // [R15]
				s_next.tx_pend = 1'b0;
			end
		end
		if (at_phase(phase_adv, s_reg.phase, srg_pkg::PH_S1P1) && s_reg.tx_last) begin
			s_next.send = 1'b0; // [R19]
			s_next.tx_last = 1'b0;
			s_next.tx_done_flag = 1'b1; // [R24]
		end

		// mode 0 receive; the pin is shared, so no start while sending
		if (at_phase(phase_adv, s_reg.phase, srg_pkg::PH_S6P2) && mode0 && s_reg.ren &&
		    !s_reg.rx_done_flag && !s_reg.receive && !s_reg.rx_arm && !s_reg.send &&
		    !s_reg.tx_arm) begin
			s_next.rx_shift = srg_pkg::RX_INIT; // [R20]
			s_next.rx_arm = 1'b1;
		end
		if (phase_adv && s_reg.rx_arm) begin
			s_next.receive = 1'b1; // [R20]
			s_next.rx_arm = 1'b0;
		end
		if (at_phase(phase_adv, s_reg.phase, srg_pkg::PH_S5P2) && s_reg.receive) begin
			s_next.rx_sample = s_reg.flt[srg_pkg::SY_DATA]; // [R21]
		end
		if (at_phase(phase_adv, s_reg.phase, srg_pkg::PH_S6P2) && s_reg.receive && !s_reg.rx_last) begin
			s_next.rx_shift = {s_reg.rx_shift[6:0], s_reg.rx_sample}; // [R21]
			if (!s_reg.rx_shift[7]) begin
				s_next.serial_buffer = {<<{s_reg.rx_shift[6:0], s_reg.rx_sample}}; // [R22]
				s_next.rx_last = 1'b1;
			end
		end
		if (at_phase(phase_adv, s_reg.phase, srg_pkg::PH_S1P1) && s_reg.rx_last) begin
			s_next.receive = 1'b0; // [R22]
			s_next.rx_last = 1'b0;
			s_next.rx_done_flag = 1'b1; // [R24]
		end

		// shift clock and data pin
		if (s_next.send || s_next.receive) begin
			if (at_phase(phase_adv, s_reg.phase, srg_pkg::PH_S3P1 - 4'h1)) begin
				s_next.sclk = 1'b0; // [R17]
			end else if (at_phase(phase_adv, s_reg.phase, srg_pkg::PH_S6P1 - 4'h1)) begin
				s_next.sclk = 1'b1; // [R21]
			end
		end else begin
			s_next.sclk = 1'b1;
		end
		s_next.doe = s_next.send; // [R16]
		s_next.dout = s_next.tx_shift[0]; // [R13]
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge mclk) begin
		if (srst) begin
			s_reg <= '0;
			s_reg.aw_rdy <= 1'b1;
			s_reg.w_rdy <= 1'b1;
			s_reg.ar_rdy <= 1'b1;
			s_reg.sclk <= 1'b1;
			s_reg.tx_shift <= 9'h000;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flops

	assign axi_out.awready = s_reg.aw_rdy;
	assign axi_out.wready = s_reg.w_rdy;
	assign axi_out.bvalid = s_reg.b_vld;
	assign axi_out.bresp = s_reg.b_resp;
	assign axi_out.arready = s_reg.ar_rdy;
	assign axi_out.rvalid = s_reg.r_vld;
	assign axi_out.rdata = s_reg.r_data;
	assign axi_out.rresp = s_reg.r_resp;
	assign pins_out.shift_clk = s_reg.sclk;
	assign pins_out.data_out = s_reg.dout;
	assign pins_out.data_oe = s_reg.doe;
	assign rate_out.tx_rate_tick = s_reg.tx_rate;
	assign rate_out.rx_rate_tick = s_reg.rx_rate;

endmodule

// ===== design/srg_pkg.sv
package srg_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_SERIAL_BUFFER  = 8'h04;
	localparam logic [7:0] OFS_RGC   = 8'h08;
	localparam logic [7:0] OFS_BRL   = 8'h0C;
	localparam logic [7:0] OFS_PWR   = 8'h10;
	localparam logic [7:0] OFS_T2C   = 8'h14;
	localparam logic [7:0] OFS_T2CNT = 8'h18;
	localparam logic [7:0] OFS_T2CAP = 8'h1C;
	localparam logic [7:0] OFS_STAT  = 8'h20;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_RI    = 0;
	localparam int CTRL_TI    = 1;
	localparam int CTRL_REN   = 4;
	localparam int CTRL_MODE  = 6;
	localparam int RGC_SRC    = 0;
	localparam int RGC_SPD    = 1;
	localparam int RGC_TX_INTERNAL_SELECT   = 2;
	localparam int RGC_RX_INTERNAL_SELECT   = 3;
	localparam int RGC_RUN    = 4;
	localparam int PWR_GEN_RATE_DOUBLER  = 6;
	localparam int PWR_TIMER_RATE_DOUBLER   = 7;
	localparam int T2C_CT2    = 1;
	localparam int T2C_TR2    = 2;
	localparam int T2C_EXT_TRIGGER_ENABLE  = 3;
	localparam int T2C_TX_CLOCK_SELECT   = 4;
	localparam int T2C_RCLK   = 5;
	localparam int T2C_EXT_TRIGGER_FLAG   = 6;
	localparam int T2C_TF2    = 7;
	localparam int STAT_SEND  = 0;
	localparam int STAT_RECV  = 1;
	localparam int STAT_PEND  = 2;
	localparam int STAT_PHASE = 8;

	////////////////////////////////////////////////////////////////////////////////
	// timing and values
	localparam logic [3:0] PH_S1P1 = 4'h0;
	localparam logic [3:0] PH_S3P1 = 4'h4;
	localparam logic [3:0] PH_S5P2 = 4'h9;
	localparam logic [3:0] PH_S6P1 = 4'hA;
	localparam logic [3:0] PH_S6P2 = 4'hB;
	localparam logic [2:0] BRG_SLOW_LAST = 3'h5;
	localparam logic [7:0] RX_INIT    = 8'hFE;
	localparam logic [7:0] TX_MARK_AT = 8'h01;
	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int SY_DATA = 0;
	localparam int SY_TRIG = 1;
	localparam int SY_CNT  = 2;
	localparam int N_SYNC  = 3;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} srg_axi_in_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} srg_axi_out_t;

	typedef struct packed {
		logic t2_count_pin;
		logic ext_trigger_pin;
		logic data_in;
	} srg_pins_in_t;

	typedef struct packed {
		logic shift_clk;
		logic data_out;
		logic data_oe;
	} srg_pins_out_t;

	typedef struct packed {
		logic tx_rate_tick;
		logic rx_rate_tick;
	} srg_rate_t;

endpackage

// ===== test/srg_monitor.sv
`timescale 1ns/1ps
module srg_monitor (
	input wire logic                   mclk,
	input wire logic                   srst,
	input wire srg_pkg::srg_axi_in_t   axi_in,
	input wire srg_pkg::srg_axi_out_t  axi_out,
	input wire logic                   timer1_overflow,
	input wire srg_pkg::srg_pins_in_t  pins_in,
	input wire srg_pkg::srg_pins_out_t pins_out,
	input wire srg_pkg::srg_rate_t     rate_out
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	logic       sck;
	logic       oe;
	logic [7:0] oe_cnt;
	assign sck = pins_out.shift_clk;
	assign oe  = pins_out.data_oe;
	// counts sampled cycles of an open send frame
	always_ff @(posedge mclk) begin
		if (srst || !oe)
			oe_cnt <= 8'h00;
		else
			oe_cnt <= oe_cnt + 8'h01;
	end
	////////////////////////////////////////////////////////////////////////
	clk_low_a: assert property ($fell(sck) |-> (!sck)[*6] ##1 sck)
		else $error("shift clock low time wrong");
	clk_high_a: assert property ($rose(sck) && oe |-> sck[*6])
		else $error("shift clock high time wrong");
	tx_shift_a: assert property (oe && $past(oe) && $changed(pins_out.data_out)
		|-> sck && $past(sck))
		else $error("send data moved outside S6P2");
	tx_len_a: assert property ($fell(oe) |-> oe_cnt inside {8'h60, 8'h61})
		else $error("send frame length wrong");
	tx_stop_a: assert property ($fell(oe) |-> sck && $past(sck, 2))
		else $error("send dropped outside S1P1");
	bresp_hold_a: assert property (axi_out.bvalid && !axi_in.bready
		|=> axi_out.bvalid && $stable(axi_out.bresp))
		else $error("write response not held");
	rdata_hold_a: assert property (axi_out.rvalid && !axi_in.rready
		|=> axi_out.rvalid && $stable(axi_out.rdata))
		else $error("read data not held");
	wr_resp_a: assert property (axi_in.awvalid && axi_out.awready && axi_in.wvalid
		&& axi_out.wready |=> !axi_out.awready ##1 axi_out.bvalid)
		else $error("write response late");
	rd_resp_a: assert property (axi_in.arvalid && axi_out.arready
		|=> axi_out.rvalid && !axi_out.arready)
		else $error("read response late");
	reset_out_a: assert property ($fell(srst) |-> sck && !oe && axi_out.awready
		&& !axi_out.bvalid && !rate_out.tx_rate_tick)
		else $error("outputs not at reset values");
	cover property ($rose(oe));
	cover property ($fell(sck) && !oe);
	cover property (axi_out.bvalid && axi_out.bresp == srg_pkg::RESP_SLVERR);
endmodule
bind srg_serial srg_monitor i_mon (.mclk(mclk), .srst(srst), .axi_in(axi_in),
	.axi_out(axi_out), .timer1_overflow(timer1_overflow), .pins_in(pins_in),
	.pins_out(pins_out), .rate_out(rate_out));

// ===== test/srg_shift_partner.sv
`timescale 1ns/1ps
module srg_shift_partner (
	input  wire logic       shift_clk,
	input  wire logic       data_oe,
	input  wire logic       data_out,
	input  wire logic       load,
	input  wire logic [7:0] load_byte,
	output      logic       data_in,
	output      logic [7:0] cap_byte,
	output      logic       done
);
	logic [7:0] tx_sr = 8'h00;
	logic [7:0] rx_sr = 8'h00;
	int         tx_n  = 0;
	int         rx_n  = 0;
	logic       last  = 1'b1;
	initial done = 1'b0;
	// released line shows the inverse so a stale bit cannot pass
	assign data_in = (rx_n != 0) ? rx_sr[0] : ~last;
	always @(posedge shift_clk) begin
		if (data_oe === 1'b1) begin
			tx_sr = {data_out, tx_sr[7:1]};
			tx_n++;
			if (tx_n == 8) begin
				tx_n = 0;
				cap_byte = tx_sr;
				done = ~done;
			end
		end else if (rx_n != 0) begin
			last = rx_sr[0];
			rx_sr = rx_sr >> 1;
			rx_n--;
		end
	end
	always @(posedge load) begin
		rx_sr = load_byte;
		rx_n = 8;
	end
endmodule

// ===== test/srg_serial_tb.sv
`timescale 1ns/1ps
module srg_serial_tb;
	logic                   mclk    = 1'b0;
	logic                   srst    = 1'b1;
	logic                   t1ov    = 1'b0;
	logic                   trig    = 1'b1;
	logic                   cnt_pin = 1'b1;
	logic                   load    = 1'b0;
	logic [7:0]             lbyte   = 8'h00;
	logic                   din;
	logic                   done;
	logic [7:0]             cap;
	srg_pkg::srg_axi_in_t   ai = '{bready: 1'b1, rready: 1'b1, default: '0};
	srg_pkg::srg_axi_out_t  ao;
	srg_pkg::srg_pins_out_t po;
	srg_pkg::srg_rate_t     ro;
	int                     miscompares = 0;
	int                     n_compared  = 0;
	int                     ntx = 0;
	int                     nrx = 0;
	logic [31:0]            txq[$];
	logic [31:0]            rv;
	logic [1:0]             rr;
	logic [31:0]            gr[4] = '{32'h16, 32'h1E, 32'h1A, 32'h14};
	logic [31:0]            gp[4] = '{32'h40, 32'h40, 32'h00, 32'h40};
	logic [31:0]            ge[4] = '{32'h3C00, 32'h3C3C, 32'h001E, 32'h0A00};

	always #25 mclk = ~mclk;
	initial begin
		#7;
		forever #200 cnt_pin = ~cnt_pin;
	end
	always @(posedge mclk) begin
		ntx <= ntx + int'(ro.tx_rate_tick);
		nrx <= nrx + int'(ro.rx_rate_tick);
	end

	srg_serial i_dut (.mclk(mclk), .srst(srst), .axi_in(ai), .axi_out(ao),
		.timer1_overflow(t1ov), .pins_in({cnt_pin, trig, din}), .pins_out(po),
		.rate_out(ro));
	srg_shift_partner i_part (.shift_clk(po.shift_clk), .data_oe(po.data_oe),
		.data_out(po.data_out), .load(load), .load_byte(lbyte), .data_in(din),
		.cap_byte(cap), .done(done));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic hang();
		miscompares++;
		$display("[FAIL] wait expected answer seen timeout");
		stop_test();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		ai.awaddr <= a;
		ai.wdata <= d;
		ai.wstrb <= 4'hF;
		ai.awvalid <= 1'b1;
		ai.wvalid <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (ao.awready) ai.awvalid <= 1'b0;
			if (ao.wready) ai.wvalid <= 1'b0;
		end while (!ao.bvalid && n < 50);
		if (n >= 50) hang();
		rr = ao.bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		ai.araddr <= a;
		ai.arvalid <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (ao.arready) ai.arvalid <= 1'b0;
		end while (!ao.rvalid && n < 50);
		if (n >= 50) hang();
		rv = ao.rdata;
		rr = ao.rresp;
	endtask
	task automatic poll(input int pos);
		int n;
		n = 0;
		do begin
			rd(srg_pkg::OFS_CTRL);
			n++;
		end while (rv[pos] !== 1'b1 && n < 200);
		if (n >= 200) hang();
	endtask
	always @(done) if (!srst) check("shift out byte", {24'h0, cap}, txq.size() ? txq.pop_front() : 'x);
	////////////////////////////////////////////////////////////////////////
	initial begin
		int b;
		int k;
		int t0;
		int r0;
		void'($urandom(14637));
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		for (int a = 0; a <= 28; a += 4) begin
			rd(8'(a));
			check("reset value", rv, 32'h0);
		end
		ai.rready <= 1'b0;
		rd(8'h24);
		ai.rready <= 1'b1;
		@(posedge mclk);
		check("unmapped read", {rv[29:0], rr}, {30'h0, srg_pkg::RESP_SLVERR});
		ai.bready <= 1'b0;
		wr(8'h24, 32'hFF);
		ai.bready <= 1'b1;
		@(posedge mclk);
		check("unmapped write", {30'h0, rr}, {30'h0, srg_pkg::RESP_SLVERR});
		for (k = 0; k < 2; k++) begin
			b = k ? $urandom_range(255) : 8'h80;
			txq.push_back(b);
			wr(srg_pkg::OFS_SERIAL_BUFFER, b);
			// second write hits a busy sender and must vanish
			if (k == 0) wr(srg_pkg::OFS_SERIAL_BUFFER, 32'h55);
			poll(srg_pkg::CTRL_TI);
			check("ctrl after send", rv, 32'h2);
			wr(srg_pkg::OFS_CTRL, 32'h0);
			rd(srg_pkg::OFS_CTRL);
			check("flag cleared", rv, 32'h0);
		end
		check("bytes left", txq.size(), 32'h0);
		b = $urandom_range(255);
		lbyte <= b[7:0];
		load <= 1'b1;
		@(posedge mclk);
		load <= 1'b0;
		wr(srg_pkg::OFS_CTRL, 32'h10);
		poll(srg_pkg::CTRL_RI);
		check("ctrl after receive", rv, 32'h11);
		rd(srg_pkg::OFS_SERIAL_BUFFER);
		check("received byte", rv, b);
		wr(srg_pkg::OFS_CTRL, 32'h40);
		for (k = 0; k < 2; k++) begin
			wr(srg_pkg::OFS_PWR, k ? 32'h80 : 32'h0);
			b = 2 * $urandom_range(5, 15);
			t0 = ntx;
			r0 = nrx;
			repeat (b) begin
				t1ov <= 1'b1;
				@(posedge mclk);
				t1ov <= 1'b0;
				repeat ($urandom_range(1, 3)) @(posedge mclk);
			end
			repeat (4) @(posedge mclk);
			check("timer1 tx ticks", ntx - t0, k ? b : b / 2);
			check("timer1 rx ticks", nrx - r0, k ? b : b / 2);
		end
		for (k = 0; k < 4; k++) begin
			wr(srg_pkg::OFS_BRL, 32'hFC);
			wr(srg_pkg::OFS_PWR, gp[k]);
			wr(srg_pkg::OFS_RGC, gr[k]);
			// long settle: first overflow may start from a zero count
			repeat (1600) @(posedge mclk);
			t0 = ntx;
			r0 = nrx;
			repeat (240) @(posedge mclk);
			check("gen tx ticks", ntx - t0, ge[k][15:8]);
			check("gen rx ticks", nrx - r0, ge[k][7:0]);
		end
		wr(srg_pkg::OFS_RGC, 32'h0);
		wr(srg_pkg::OFS_T2CAP, 32'hFFF0);
		wr(srg_pkg::OFS_T2CNT, 32'hFFF0);
		wr(srg_pkg::OFS_T2C, 32'h1C);
		repeat (100) @(posedge mclk);
		t0 = ntx;
		r0 = nrx;
		repeat (320) @(posedge mclk);
		check("timer2 tx ticks", ntx - t0, 32'd10);
		check("timer2 rx ticks", nrx - r0, 32'd0);
		rd(srg_pkg::OFS_T2C);
		check("timer2 flags", rv, 32'h1C);
		trig <= 1'b0;
		repeat (8) @(posedge mclk);
		trig <= 1'b1;
		repeat (8) @(posedge mclk);
		rd(srg_pkg::OFS_T2C);
		check("trigger flag", rv, 32'h5C);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		rd(srg_pkg::OFS_T2C);
		check("second reset", rv, 32'h0);
		stop_test();
	end
endmodule
